// ===== logic/charger_power_mode_controller.v
`timescale 1ns/1ps
`include "charger_consts.vh"
module charger_power_mode_controller #(
  parameter WAKE_CYCLES = `LONG_WAKE_CYC,
  parameter WAKE_W      = 28
) (
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  input  wire       vin_above_uvlo_i,
  input  wire       vin_above_ovp_i,
  input  wire       vin_above_dpm_i,
  input  wire       bat_present_i,
  input  wire       bat_above_uvlo_i,
  input  wire       bat_above_uvlo_hyst_i,
  input  wire       bat_above_max_uvlo_i,
  input  wire       bat_overcurrent_i,
  input  wire       charge_done_i,
  input  wire       int_pending_i,
  input  wire       pushbutton_n_i,
  input  wire       low_power_pin_n_i,
  input  wire       charge_enable_n_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  output reg  [2:0] mode_o,
  output reg        discharge_switch_on_o,
  output reg        always_on_rail_on_o,
  output reg        always_on_from_bat_o,
  output reg        aux_output_on_o,
  output reg        osc_enable_o,
  output reg        serial_enable_o,
  output reg        converter_enable_o,
  output reg        adc_continuous_o,
  output reg        int_enable_o,
  output reg        power_good_active_o,
  output reg        system_from_input_o,
  output reg        charging_o,
  output reg  [2:0] bat_uv_select_o
);

  //////////////////////////////////////////////////////////////////////
  // mode codes

  localparam MODE_SHIP    = 3'd0;
  localparam MODE_WAKE    = 3'd1;
  localparam MODE_CHARGER = 3'd2;
  localparam MODE_ACTIVE  = 3'd3;
  localparam MODE_LOWPWR  = 3'd4;

  reg  [2:0] mode;
  reg  [2:0] next_mode;
  reg  [2:0] eval_mode;

  reg  [7:0] bat_uv_ctl;
  reg  [7:0] reg_out_ctl;
  reg  [7:0] pb_ctl;
  reg  [7:0] chip_ctl0;
  reg  [4:0] chip_ctl1;
  reg  [7:0] chip_ctl2;

  reg        bat_present_q;
  reg        bat_good;
  reg        ocp_trip;
  reg        aux_hold;
  reg  [7:0] rd_data;

  wire       serial_on;
  wire       serial_busy;
  wire [7:0] reg_addr;
  wire [7:0] wr_data;
  wire       wr_stb;
  wire       long_press;

  //////////////////////////////////////////////////////////////////////
  // condition decode

  // an input above overvoltage is not a usable supply
  wire vin_valid = vin_above_uvlo_i & ~vin_above_ovp_i;
  wire ship_req  = chip_ctl0[`BIT_SHIP_REQ];

  // entry waits for input removal and button release; charge pin not used
  wire ship_go   = ship_req & pushbutton_n_i;

  wire lp_ok     = ~low_power_pin_n_i & ~vin_above_uvlo_i & pushbutton_n_i &
                   ~serial_busy & ~int_pending_i;

  wire insert    = bat_present_i & ~bat_present_q & bat_above_uvlo_i &
                   ~vin_valid;

  wire ship_wake = pushbutton_n_i & long_press & bat_above_max_uvlo_i;

  wire entering_ship = (next_mode == MODE_SHIP) && (mode != MODE_SHIP);

  function is_mode;
    input [2:0] m;
    input [2:0] a;
    input [2:0] b;
    begin
      is_mode = (m == a) || (m == b);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // mode selection

  // fixed priority, evaluated every cycle
  always @* begin
    if (vin_valid)
      eval_mode = MODE_CHARGER;
    else if (ship_go)
      eval_mode = MODE_SHIP;
    else if (lp_ok)
      eval_mode = MODE_LOWPWR;
    else
      eval_mode = MODE_ACTIVE;
  end

  always @* begin
    next_mode = mode;
    if (insert) begin
      next_mode = MODE_WAKE;
    end else begin
      case (mode)
        MODE_SHIP: begin
          // latched off until input or a completed long press
          if (vin_above_uvlo_i)
            next_mode = eval_mode;
          else if (ship_wake)
            next_mode = MODE_ACTIVE;
          else
            next_mode = MODE_SHIP;
        end
        MODE_WAKE: begin
          if (vin_valid)
            next_mode = MODE_CHARGER;
          else if (pushbutton_n_i)
            next_mode = MODE_SHIP;
          else if (long_press)
            next_mode = MODE_ACTIVE;
          else
            next_mode = MODE_WAKE;
        end
        MODE_CHARGER,
        MODE_ACTIVE,
        MODE_LOWPWR: next_mode = eval_mode;
        default: next_mode = MODE_WAKE;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode          <= MODE_WAKE;
      bat_present_q <= 1'b0;
    end else begin
      mode          <= next_mode;
      bat_present_q <= bat_present_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pushbutton timing

  wake_press_timer #(
    .CYCLES (WAKE_CYCLES),
    .W      (WAKE_W)
  ) u_wake_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (is_mode(mode, MODE_SHIP, MODE_WAKE)),
    .hold_i    (~pushbutton_n_i),
    .reached_o (long_press)
  );

  //////////////////////////////////////////////////////////////////////
  // serial register access

  // serial port only alive in charger and active battery modes
  assign serial_on = is_mode(mode, MODE_CHARGER, MODE_ACTIVE);

  serial_reg_target u_serial (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .enable_i   (serial_on),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .reg_addr_o (reg_addr),
    .wr_data_o  (wr_data),
    .wr_stb_o   (wr_stb),
    .rd_data_i  (rd_data),
    .busy_o     (serial_busy)
  );

  always @* begin
    case (reg_addr)
      `OFS_BAT_UV_CTL:  rd_data = bat_uv_ctl;
      `OFS_REG_OUT_CTL: rd_data = reg_out_ctl;
      `OFS_PB_CTL:      rd_data = pb_ctl;
      `OFS_CHIP_CTL0:   rd_data = chip_ctl0;
      `OFS_CHIP_CTL1:   rd_data = {chip_ctl1, mode};
      `OFS_CHIP_CTL2:   rd_data = chip_ctl2;
      default:          rd_data = `UNMAPPED_DATA;
    endcase
  end

  // the ship request is only dropped by a host write or by entering ship;
  // nothing else, watchdog expiry included, touches it
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bat_uv_ctl  <= `RST_BAT_UV_CTL;
      reg_out_ctl <= `RST_REG_OUT_CTL;
      pb_ctl      <= `RST_PB_CTL;
      chip_ctl0   <= `RST_CHIP_CTL0;
      chip_ctl1   <= `RST_CHIP_CTL1;
      chip_ctl2   <= `RST_CHIP_CTL2;
    end else begin
      if (entering_ship)
        chip_ctl0[`BIT_SHIP_REQ] <= 1'b0;
      if (wr_stb) begin
        case (reg_addr)
          `OFS_BAT_UV_CTL:  bat_uv_ctl  <= wr_data;
          `OFS_REG_OUT_CTL: reg_out_ctl <= wr_data;
          `OFS_PB_CTL:      pb_ctl      <= wr_data;
          `OFS_CHIP_CTL0:   chip_ctl0   <= wr_data;
          `OFS_CHIP_CTL1:   chip_ctl1   <= wr_data[7:3];
          `OFS_CHIP_CTL2:   chip_ctl2   <= wr_data;
          default:          chip_ctl2   <= chip_ctl2;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // battery path protection

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bat_good <= 1'b0;
      ocp_trip <= 1'b0;
      aux_hold <= 1'b0;
    end else begin
      if (!bat_above_uvlo_i)
        bat_good <= 1'b0;
      else if (bat_above_uvlo_hyst_i)
        bat_good <= 1'b1;
      // overcurrent latch stays until an input supply returns or ship
      if (bat_overcurrent_i && mode != MODE_SHIP)
        ocp_trip <= 1'b1;
      else if (vin_valid || mode == MODE_SHIP)
        ocp_trip <= 1'b0;
      // freeze the auxiliary enable on the way into low power
      if (next_mode == MODE_LOWPWR && mode != MODE_LOWPWR)
        aux_hold <= reg_out_ctl[`BIT_AUX_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // function gating per mode

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode_o                <= MODE_WAKE;
      discharge_switch_on_o <= 1'b0;
      always_on_rail_on_o   <= 1'b0;
      always_on_from_bat_o  <= 1'b0;
      aux_output_on_o       <= 1'b0;
      osc_enable_o          <= 1'b0;
      serial_enable_o       <= 1'b0;
      converter_enable_o    <= 1'b0;
      adc_continuous_o      <= 1'b0;
      int_enable_o          <= 1'b0;
      power_good_active_o   <= 1'b0;
      system_from_input_o   <= 1'b0;
      charging_o            <= 1'b0;
      bat_uv_select_o       <= 3'h0;
    end else begin
      mode_o <= mode;
      // battery feeds the system rail only out of ship with no input
      discharge_switch_on_o <= is_mode(mode, MODE_ACTIVE, MODE_LOWPWR) &
                               ~vin_valid & bat_good & ~ocp_trip;
      always_on_rail_on_o   <= (mode != MODE_SHIP);
      always_on_from_bat_o  <= is_mode(mode, MODE_LOWPWR, MODE_ACTIVE) |
                               (mode == MODE_WAKE);
      case (mode)
        MODE_CHARGER, MODE_ACTIVE:
          aux_output_on_o <= reg_out_ctl[`BIT_AUX_EN];
        MODE_LOWPWR:
          aux_output_on_o <= aux_hold;
        default:
          aux_output_on_o <= 1'b0;
      endcase
      // clocks run whenever timing or serial access is needed
      osc_enable_o        <= is_mode(mode, MODE_CHARGER, MODE_ACTIVE) |
                             is_mode(mode, MODE_WAKE, MODE_SHIP) &
                             ~pushbutton_n_i;
      serial_enable_o     <= serial_on;
      converter_enable_o  <= serial_on;
      adc_continuous_o    <= (mode == MODE_CHARGER);
      int_enable_o        <= serial_on;
      power_good_active_o <= is_mode(mode, MODE_LOWPWR, MODE_ACTIVE);
      system_from_input_o <= (mode == MODE_CHARGER) & vin_above_dpm_i;
      // charge pin only counts in charger mode
      charging_o          <= (mode == MODE_CHARGER) & vin_above_dpm_i &
                             ~charge_enable_n_i &
                             chip_ctl0[`BIT_CHG_EN] & ~charge_done_i;
      bat_uv_select_o     <= bat_uv_ctl[`FLD_UV_SEL_HI:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // notes on the outside world
  //
  // after a hardware reset taken with the low-power pin low, the button
  // must stay pressed until the rails return; the wake state relies on
  // that to reach active battery mode instead of dropping to ship.
  //
  // the pending ship entry survives anything short of a host write or
  // the entry itself, so a lost host still ends in ship mode.

endmodule // charger_power_mode_controller

// ===== logic/serial_reg_target.v
`timescale 1ns/1ps
`include "charger_consts.vh"
module serial_reg_target (
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  input  wire       enable_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg  [7:0] reg_addr_o,
  output reg  [7:0] wr_data_o,
  output reg        wr_stb_o,
  input  wire [7:0] rd_data_i,
  output reg        busy_o
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_PTR   = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg       rd_dir;
  reg       nack;
  reg       scl_q;
  reg       sda_q;
  reg       armed;

  wire start  = scl_i & scl_q & sda_q & ~sda_i;
  wire stop   = scl_i & scl_q & ~sda_q & sda_i;
  wire rise   = scl_i & ~scl_q;
  wire fall   = ~scl_i & scl_q & armed;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rd_dir <= 1'b0;
      nack <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      armed <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      reg_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      wr_stb_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_stb_o <= 1'b0;
      if (!enable_i || stop) begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
        busy_o <= 1'b0;
      end else if (start) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_o <= 1'b0;
        busy_o <= 1'b1;
        armed <= 1'b0;
      end else if (state != ST_IDLE) begin
        if (rise) begin
          armed <= 1'b1;
          if (bit_cnt < 4'h8)
            shift <= {shift[6:0], sda_i};
          else
            nack <= sda_i;
        end
        if (fall && bit_cnt < 4'h7) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (state == ST_RDATA) begin
            sda_oe_o <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end else if (fall && bit_cnt == 4'h7) begin
          bit_cnt <= 4'h8;
          sda_oe_o <= (state != ST_RDATA);
          case (state)
            ST_ADDR: begin
              rd_dir <= shift[0];
              if (shift[7:1] != `DEV_ADDR) begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
              end
            end
            ST_PTR: reg_addr_o <= shift;
            ST_WDATA: begin
              wr_data_o <= shift;
              wr_stb_o <= 1'b1;
            end
            ST_RDATA: reg_addr_o <= reg_addr_o + 8'h01;
            default: state <= ST_IDLE;
          endcase
        end else if (fall) begin
          bit_cnt <= 4'h0;
          sda_oe_o <= 1'b0;
          case (state)
            ST_ADDR: begin
              state <= rd_dir ? ST_RDATA : ST_PTR;
              if (rd_dir) begin
                sda_oe_o <= ~rd_data_i[7];
                tx <= {rd_data_i[6:0], 1'b0};
              end
            end
            ST_PTR: state <= ST_WDATA;
            ST_WDATA: reg_addr_o <= reg_addr_o + 8'h01;
            ST_RDATA: begin
              if (nack) begin
                state <= ST_IDLE;
              end else begin
                sda_oe_o <= ~rd_data_i[7];
                tx <= {rd_data_i[6:0], 1'b0};
              end
            end
            default: state <= ST_IDLE;
          endcase
        end
      end
    end
  end

endmodule // serial_reg_target

// ===== logic/wake_press_timer.v
`timescale 1ns/1ps
module wake_press_timer #(
  parameter CYCLES = 250000,
  parameter W      = 28
) (
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire run_i,
  input  wire hold_i,
  output reg  reached_o
);

  reg [W-1:0] count;

  // counts while held, clears as soon as the hold ends
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count     <= {W{1'b0}};
      reached_o <= 1'b0;
    end else if (!run_i || !hold_i) begin
      count     <= {W{1'b0}};
      reached_o <= 1'b0;
    end else if (count < CYCLES[W-1:0]) begin
      count     <= count + {{(W-1){1'b0}}, 1'b1};
    end else begin
      reached_o <= 1'b1;
    end
  end

endmodule // wake_press_timer

// ===== pkg/charger_consts.vh
// Function
// - ship mode holds device and switch off until input valid or long press released; code leaves it for any input above undervoltage, overvoltage too
// - battery insertion with no valid input leads into ship mode, or active battery mode if the button is held past the wake timer
// - ship request with valid input waits until input removed, charge pin ignored
// - ship request with pushbutton low waits for pushbutton high
// - pushbutton wakes from ship only with battery above highest undervoltage threshold
// - host may clear ship request while input valid, cancelling entry
// - watchdog expiry never clears ship request; pending entry still completes
// - in ship mode only input comparator and pushbutton stay alive
// - serial, converter, interrupt, charge pin and power good gated per mode
// - low power entered only with pin low, no input, button high, idle bus
// - low power stops serial and converter, rail from battery, oscillators off
// - auxiliary output keeps its pre-entry enable state during low power
// - low power left when pin goes high or input rises above undervoltage
// - overvoltage input with pin low gives active battery mode
// - button low with pin low gives active battery mode with clocks
// - discharge switch on in active battery or low power mode with battery good and no input
// - discharge switch opens on battery overcurrent
// - discharge switch off below battery threshold, back on above hysteresis level
// - charger mode keeps converter on and converts continuously
// - charger mode feeds rail from input above dynamic level and charges
// - insertion raises rail, samples button, ship or wake timer then power up
// - reads of unmapped register addresses return all ones
`ifndef CHARGER_CONSTS_VH
`define CHARGER_CONSTS_VH

`define DEV_ADDR          7'h6B
`define OFS_BAT_UV_CTL    8'h16
`define OFS_REG_OUT_CTL   8'h1D
`define OFS_PB_CTL        8'h30
`define OFS_CHIP_CTL0     8'h35
`define OFS_CHIP_CTL1     8'h36
`define OFS_CHIP_CTL2     8'h37
`define UNMAPPED_DATA     8'hFF

`define RST_BAT_UV_CTL    8'h00
`define RST_REG_OUT_CTL   8'h00
`define RST_PB_CTL        8'h00
`define RST_CHIP_CTL0     8'h02
`define RST_CHIP_CTL1     5'h00
`define RST_CHIP_CTL2     8'h00

`define BIT_SHIP_REQ      7
`define BIT_CHG_EN        1
`define BIT_AUX_EN        7
`define FLD_UV_SEL_HI     2
`define FLD_MODE_HI       2

`define CLK_KHZ           125000
`define LONG_WAKE_MS      2
`define LONG_WAKE_CYC     (`LONG_WAKE_MS * `CLK_KHZ)

`endif

// ===== verification/charger_power_mode_controller_checker.sv
`timescale 1ns/1ps
module charger_power_mode_controller_checker (
  input wire       sys_clk_i,
  input wire       rst_n_i,
  input wire       vin_above_uvlo_i,
  input wire       pushbutton_n_i,
  input wire       low_power_pin_n_i,
  input wire       bat_overcurrent_i,
  input wire [2:0] mode_o,
  input wire       discharge_switch_on_o,
  input wire       aux_output_on_o,
  input wire       osc_enable_o,
  input wire       serial_enable_o,
  input wire       converter_enable_o,
  input wire       adc_continuous_o,
  input wire       int_enable_o,
  input wire       power_good_active_o,
  input wire       charging_o,
  input wire       always_on_from_bat_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_lp_held;
    mode_o == 3'h4 && (low_power_pin_n_i || vin_above_uvlo_i);
  endsequence
  sequence s_ocp_hit;
    mode_o == 3'h3 && bat_overcurrent_i;
  endsequence
  property p_ship_off;
    mode_o == 3'h0 |-> !discharge_switch_on_o && !serial_enable_o && !converter_enable_o && !int_enable_o;
  endproperty
  property p_gating;
    (serial_enable_o || int_enable_o || charging_o) |-> (mode_o == 3'h2 || mode_o == 3'h3) && !(charging_o && mode_o != 3'h2);
  endproperty
  property p_power_good;
    power_good_active_o |-> mode_o == 3'h3 || mode_o == 3'h4;
  endproperty
  property p_lp_entry;
    mode_o == 3'h4 && $past(mode_o) != 3'h4 |-> $past(!low_power_pin_n_i, 2) && $past(!vin_above_uvlo_i, 2) && $past(pushbutton_n_i, 2);
  endproperty
  property p_lp_outputs;
    mode_o == 3'h4 |-> !serial_enable_o && !converter_enable_o && !osc_enable_o && always_on_from_bat_o;
  endproperty
  property p_aux_hold;
    mode_o == 3'h4 && $past(mode_o) == 3'h4 |-> $stable(aux_output_on_o);
  endproperty
  property p_lp_exit;
    s_lp_held |-> ##[1:3] mode_o != 3'h4;
  endproperty
  property p_ocp;
    s_ocp_hit |-> ##[1:3] !discharge_switch_on_o;
  endproperty
  property p_charger;
    mode_o == 3'h2 |-> converter_enable_o && adc_continuous_o;
  endproperty
  property p_one_mode;
    mode_o <= 3'h4;
  endproperty
  a_ship_off: assert property (p_ship_off) else $error("ship mode left a function on");
  a_gating: assert property (p_gating) else $error("function active in wrong mode");
  a_power_good: assert property (p_power_good) else $error("power good input active in wrong mode");
  a_lp_entry: assert property (p_lp_entry) else $error("low power entered without its conditions");
  a_lp_outputs: assert property (p_lp_outputs) else $error("low power outputs wrong");
  a_aux_hold: assert property (p_aux_hold) else $error("aux output changed in low power");
  a_lp_exit: assert property (p_lp_exit) else $error("low power not left");
  a_ocp: assert property (p_ocp) else $error("discharge switch kept on under overcurrent");
  a_charger: assert property (p_charger) else $error("charger mode converter off");
  a_one_mode: assert property (p_one_mode) else $error("illegal mode code");
endmodule // charger_power_mode_controller_checker

bind charger_power_mode_controller charger_power_mode_controller_checker i_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .vin_above_uvlo_i(vin_above_uvlo_i), .pushbutton_n_i(pushbutton_n_i),
  .low_power_pin_n_i(low_power_pin_n_i), .bat_overcurrent_i(bat_overcurrent_i), .mode_o(mode_o),
  .discharge_switch_on_o(discharge_switch_on_o), .aux_output_on_o(aux_output_on_o), .osc_enable_o(osc_enable_o),
  .serial_enable_o(serial_enable_o), .converter_enable_o(converter_enable_o), .adc_continuous_o(adc_continuous_o),
  .int_enable_o(int_enable_o), .power_good_active_o(power_good_active_o), .charging_o(charging_o),
  .always_on_from_bat_o(always_on_from_bat_o));

// ===== verification/charger_power_mode_controller_tb.sv
`timescale 1ns/1ps
`include "charger_consts.vh"
module charger_power_mode_controller_tb;
  localparam WAKE = 20;
  reg         sys_clk_i, rst_n_i, vin_uvlo, vin_ovp, input_dynamic_level, bat_pres, bat_uv, bat_hyst, bat_max;
  reg         bat_oc, chg_done, int_pend, pb_n, lp_n, ce_n;
  integer     mismatches, n_tests, cycles;
  wire        scl, host_sda, sda_out, sda_oe, dis, rail, from_bat, aux, osc, ser, conv, adc, inte, pg, sysin, chg;
  wire [2:0]  mode, uvsel;
  wire        sda_w = host_sda & ~sda_oe;
  i2c_host_model i_host (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  charger_power_mode_controller #(.WAKE_CYCLES(WAKE), .WAKE_W(28)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .vin_above_uvlo_i(vin_uvlo), .vin_above_ovp_i(vin_ovp),
    .vin_above_dpm_i(input_dynamic_level), .bat_present_i(bat_pres), .bat_above_uvlo_i(bat_uv), .bat_above_uvlo_hyst_i(bat_hyst),
    .bat_above_max_uvlo_i(bat_max), .bat_overcurrent_i(bat_oc), .charge_done_i(chg_done), .int_pending_i(int_pend),
    .pushbutton_n_i(pb_n), .low_power_pin_n_i(lp_n), .charge_enable_n_i(ce_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .mode_o(mode), .discharge_switch_on_o(dis), .always_on_rail_on_o(rail),
    .always_on_from_bat_o(from_bat), .aux_output_on_o(aux), .osc_enable_o(osc), .serial_enable_o(ser),
    .converter_enable_o(conv), .adc_continuous_o(adc), .int_enable_o(inte), .power_good_active_o(pg),
    .system_from_input_o(sysin), .charging_o(chg), .bat_uv_select_o(uvsel));
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task check_flag(input act, input exp);
    begin
      n_tests = n_tests + 1;
      if (act !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: flag got %b expected %b", $time, act, exp);
      end
    end
  endtask
  task check_val(input [7:0] act, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (act !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: value got %h expected %h", $time, act, exp);
      end
    end
  endtask
  task settle;
    repeat (4) @(negedge sys_clk_i);
  endtask
  task check_mode(input [2:0] exp);
    begin
      settle;
      check_val({5'h00, mode}, {5'h00, exp});
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      i_host.write_reg(a, d);
      check_flag(i_host.ack_ok, 1'b1);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    reg [7:0] v;
    begin
      i_host.read_reg(a, v);
      check_flag(i_host.ack_ok, 1'b1);
      check_val(v, exp);
    end
  endtask
  task reg_case(input [7:0] a, input [7:0] rst_v, input [7:0] wv, input [7:0] back);
    begin
      rd(a, rst_v);
      wr(a, wv);
      rd(a, back);
    end
  endtask
  // long press then release, as a user wakes the device
  task press(input integer n);
    begin
      pb_n = 1'b0;
      repeat (n) @(negedge sys_clk_i);
      pb_n = 1'b1;
      settle;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  initial begin
    {rst_n_i, vin_uvlo, vin_ovp, input_dynamic_level, bat_pres, bat_uv, bat_hyst, bat_max} = 8'h00;
    {bat_oc, chg_done, int_pend, ce_n, pb_n, lp_n} = 6'h03;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (2) @(negedge sys_clk_i);
    check_val({5'h00, mode}, 8'h01);
    rst_n_i = 1'b1;
    {bat_pres, bat_uv, bat_hyst, bat_max} = 4'hF;
    check_mode(3'h0);
    check_flag(dis, 1'b0);
    check_flag(rail, 1'b0);
    vin_uvlo = 1'b1;
    input_dynamic_level = 1'b1;
    check_mode(3'h2);
    check_flag(sysin, 1'b1);
    check_flag(chg, 1'b1);
    ce_n = 1'b1;
    settle;
    check_flag(chg, 1'b0);
    ce_n = 1'b0;
    reg_case(`OFS_BAT_UV_CTL, 8'h00, 8'hA5, 8'hA5);
    check_val({5'h00, uvsel}, 8'h05);
    reg_case(`OFS_REG_OUT_CTL, 8'h00, 8'hA5, 8'hA5);
    reg_case(`OFS_PB_CTL, 8'h00, 8'hA5, 8'hA5);
    reg_case(`OFS_CHIP_CTL2, 8'h00, 8'hA5, 8'hA5);
    reg_case(`OFS_CHIP_CTL1, 8'h02, 8'hFF, 8'hFA);
    reg_case(`OFS_CHIP_CTL0, 8'h02, 8'h02, 8'h02);
    rd(8'h20, `UNMAPPED_DATA);
    wr(`OFS_CHIP_CTL0, 8'h82);
    check_mode(3'h2);
    wr(`OFS_CHIP_CTL0, 8'h02);
    {vin_uvlo, input_dynamic_level} = 2'b00;
    check_mode(3'h3);
    check_flag(dis, 1'b1);
    vin_uvlo = 1'b1;
    check_mode(3'h2);
    wr(`OFS_CHIP_CTL0, 8'h82);
    pb_n = 1'b0;
    vin_uvlo = 1'b0;
    check_mode(3'h3);
    pb_n = 1'b1;
    check_mode(3'h0);
    bat_max = 1'b0;
    press(WAKE + 5);
    check_mode(3'h0);
    bat_max = 1'b1;
    press(WAKE + 5);
    check_mode(3'h3);
    rd(`OFS_CHIP_CTL0, 8'h02);
    {bat_uv, bat_hyst} = 2'b00;
    settle;
    check_flag(dis, 1'b0);
    bat_uv = 1'b1;
    settle;
    check_flag(dis, 1'b0);
    bat_hyst = 1'b1;
    settle;
    check_flag(dis, 1'b1);
    int_pend = 1'b1;
    lp_n = 1'b0;
    check_mode(3'h3);
    int_pend = 1'b0;
    check_mode(3'h4);
    check_flag(ser | osc, 1'b0);
    check_flag(from_bat, 1'b1);
    check_flag(aux, 1'b1);
    pb_n = 1'b0;
    check_mode(3'h3);
    check_flag(osc & ser, 1'b1);
    pb_n = 1'b1;
    check_mode(3'h4);
    lp_n = 1'b1;
    check_mode(3'h3);
    lp_n = 1'b0;
    check_mode(3'h4);
    {vin_uvlo, vin_ovp} = 2'b11;
    check_mode(3'h3);
    vin_ovp = 1'b0;
    check_mode(3'h2);
    lp_n = 1'b1;
    vin_uvlo = 1'b0;
    check_mode(3'h3);
    bat_oc = 1'b1;
    settle;
    check_flag(dis, 1'b0);
    {lp_n, pb_n, rst_n_i} = 3'b000;
    settle;
    rst_n_i = 1'b1;
    repeat (WAKE) settle;
    check_mode(3'h3);
    pb_n = 1'b1;
    check_mode(3'h4);
    complete_run;
  end
endmodule // charger_power_mode_controller_tb

// ===== verification/i2c_host_model.sv
`timescale 1ns/1ps
`include "charger_consts.vh"
module i2c_host_model (
  input  wire sys_clk_i,
  input  wire sda_i,
  output reg  scl_o,
  output reg  sda_o
);
  reg     ack_ok;
  integer half_cycles;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    ack_ok = 1'b1;
    half_cycles = 4;
  end
  task half;
    repeat (half_cycles) @(negedge sys_clk_i);
  endtask
  // one scl pulse; the line is read at the end of the high phase
  task clk_bit(input reg b, output reg r);
    begin
      sda_o = b;
      half;
      scl_o = 1'b1;
      half;
      r = sda_i;
      scl_o = 1'b0;
    end
  endtask
  task start;
    begin
      sda_o = 1'b1;
      half;
      scl_o = 1'b1;
      half;
      sda_o = 1'b0;
      half;
      scl_o = 1'b0;
    end
  endtask
  task stop;
    begin
      sda_o = 1'b0;
      half;
      scl_o = 1'b1;
      half;
      sda_o = 1'b1;
      half;
    end
  endtask
  task send(input [7:0] d);
    reg     r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      if (r !== 1'b0) ack_ok = 1'b0;
    end
  endtask
  task write_reg(input [7:0] a, input [7:0] d);
    begin
      ack_ok = 1'b1;
      start;
      send({`DEV_ADDR, 1'b0});
      send(a);
      send(d);
      stop;
    end
  endtask
  // set pointer, repeated start, one byte, nack ends the read
  task read_reg(input [7:0] a, output [7:0] d);
    reg     r;
    integer i;
    begin
      ack_ok = 1'b1;
      start;
      send({`DEV_ADDR, 1'b0});
      send(a);
      start;
      send({`DEV_ADDR, 1'b1});
      for (i = 7; i >= 0; i = i - 1) begin
        clk_bit(1'b1, r);
        d[i] = r;
      end
      clk_bit(1'b1, r);
      stop;
    end
  endtask
endmodule // i2c_host_model
